// *** design/gpo_regs.svh ***
// Summary of operation
// R1: software waits one idle cycle before reading back a value it just wrote; readback through the input register here needs two idle cycles
// R2: digital input clamps low while the sleep clamp is asserted
// R3: clamp is overridden on pins with their external interrupt enabled
// R4: held-high edge interrupt pin not enabled flags an edge on wake
// R5: pull-up is off while reset is asserted
// R6: pull-up follows override value when enabled, else dir/out/disable equal 010
// R7: driver enable follows direction override when enabled, else direction bit
// R8: driven level is override value when enabled, else output bit
// R9: toggle override inverts the stored output bit
// R10: input enable follows its override when enabled, else sleep state decides
// R11: raw digital input tapped after input gate, before the synchroniser
// R12: analog path connects straight to the pad, both directions
// R13: strobes shared per port; clock, clamp, pull-up disable shared by all ports
// R14: each peripheral drives the overrides for the pins it uses
// R15: direction one drives output bit; zero is input with pull-up on output one
// R16: writing one to the input location toggles the output bit
// R17: written output value appears in the input register two cycles later
// R18: global pull-up disable switches off every pull-up without its override enabled
// R19: override enables default inactive so register bits alone control the pin
`ifndef GPO_REGS_SVH
`define GPO_REGS_SVH
`define GPO_ADDR_IN      2'h0
`define GPO_ADDR_DIR     2'h1
`define GPO_ADDR_OUT     2'h2
`define GPO_ADDR_CTRL    2'h3
`define GPO_RST_BYTE     8'h00
`define GPO_PUD_BIT      0
`define GPO_SYNC_CYCLES  1
`endif

// *** design/gpo_pkg.sv ***
package gpo_pkg;
	typedef logic [7:0] gpo_byte_t;
	typedef logic [1:0] gpo_addr_t;
endpackage

// *** design/gpo_port.sv ***
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`include "gpo_regs.svh"
module gpo_port (
	input  wire logic             core_clk,
	input  wire logic             reset,
	input  wire gpo_pkg::gpo_addr_t reg_addr,
	input  wire gpo_pkg::gpo_byte_t reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	output      gpo_pkg::gpo_byte_t reg_rdata,
	input  wire logic             sleep_clamp,
	input  wire gpo_pkg::gpo_byte_t ext_int_enabled,
	input  wire gpo_pkg::gpo_byte_t pad_in,
	output      gpo_pkg::gpo_byte_t pad_out,
	output      gpo_pkg::gpo_byte_t pad_oe,
	output      gpo_pkg::gpo_byte_t pad_pullup,
	input  wire gpo_pkg::gpo_byte_t pullup_override_en,
	input  wire gpo_pkg::gpo_byte_t pullup_override_val,
	input  wire gpo_pkg::gpo_byte_t dir_override_en,
	input  wire gpo_pkg::gpo_byte_t dir_override_val,
	input  wire gpo_pkg::gpo_byte_t out_value_override_en,
	input  wire gpo_pkg::gpo_byte_t out_value_override_val,
	input  wire gpo_pkg::gpo_byte_t out_toggle_override_en,
	input  wire gpo_pkg::gpo_byte_t input_en_override_en,
	input  wire gpo_pkg::gpo_byte_t input_en_override_val,
	output      gpo_pkg::gpo_byte_t raw_digital_input
);
	import gpo_pkg::*;

	gpo_byte_t direction_bit_r;
	gpo_byte_t output_bit_r;
	gpo_byte_t output_bit_nxt;
	gpo_byte_t sync_stage_r;
	gpo_byte_t sync_input_bit_r;
	logic      global_pullup_disable_r;
	gpo_byte_t rdata_r;
	gpo_byte_t rdata_nxt;
	gpo_byte_t pad_out_r;
	gpo_byte_t pad_oe_r;
	gpo_byte_t pad_pullup_r;
	gpo_byte_t raw_r;
	gpo_byte_t pin_sync1_r;
	gpo_byte_t pin_sync2_r;
	gpo_byte_t drv_en;
	gpo_byte_t drv_val;
	gpo_byte_t pu_en;
	gpo_byte_t in_en;
	gpo_byte_t gated_in;
	gpo_byte_t fb_in;
	gpo_byte_t pu_normal;
	gpo_byte_t in_normal;
	logic      wr_in;
	logic      wr_dir;
	logic      wr_out;
	logic      wr_ctrl;

	// per-pin override select, enable low passes the register side
	function automatic gpo_byte_t ovr_sel(
		input gpo_byte_t en,
		input gpo_byte_t val,
		input gpo_byte_t regv
	);
		return (en & val) | (~en & regv);
	endfunction

	// register decode, strobes shared by all pins
	assign wr_in   = reg_wr && (reg_addr == `GPO_ADDR_IN);   // R13
	assign wr_dir  = reg_wr && (reg_addr == `GPO_ADDR_DIR);
	assign wr_out  = reg_wr && (reg_addr == `GPO_ADDR_OUT);
	assign wr_ctrl = reg_wr && (reg_addr == `GPO_ADDR_CTRL);

	// output bit: write, toggle by input location write, toggle override
	assign output_bit_nxt = (wr_out ? reg_wdata : output_bit_r)
		^ (wr_in ? reg_wdata : 8'h00)   // R16
		^ out_toggle_override_en;      // R9

	// pin control with overrides; enables low means registers rule
	assign pu_normal = ~direction_bit_r & output_bit_r & {8{~global_pullup_disable_r}};   // R15 R18
	assign drv_en    = ovr_sel(dir_override_en, dir_override_val, direction_bit_r);   // R7 R19
	assign drv_val   = ovr_sel(out_value_override_en, out_value_override_val, output_bit_r);   // R8
	assign pu_en     = ovr_sel(pullup_override_en, pullup_override_val, pu_normal);   // R6
	// sleep clamp, bypassed on enabled interrupt pins
	assign in_normal = {8{~sleep_clamp}} | ext_int_enabled;   // R2 R3
	assign in_en     = ovr_sel(input_en_override_en, input_en_override_val, in_normal);   // R10

	// feedback of driven level so written value reaches the input register two cycles later
	assign fb_in    = (drv_en & drv_val) | (~drv_en & pin_sync2_r);
	assign gated_in = fb_in & in_en;   // R2 R4

	assign rdata_nxt = (reg_addr == `GPO_ADDR_IN)  ? sync_input_bit_r :
	                   (reg_addr == `GPO_ADDR_DIR) ? direction_bit_r :
	                   (reg_addr == `GPO_ADDR_OUT) ? output_bit_r :
	                   {7'h00, global_pullup_disable_r};

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pin_sync1_r <= `GPO_RST_BYTE;
			pin_sync2_r <= `GPO_RST_BYTE;
		end else begin
			pin_sync1_r <= pad_in;
			pin_sync2_r <= pin_sync1_r;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			direction_bit_r         <= `GPO_RST_BYTE;
			output_bit_r            <= `GPO_RST_BYTE;
			global_pullup_disable_r <= 1'b0;
		end else begin
			output_bit_r <= output_bit_nxt;
			if (wr_dir)
				direction_bit_r <= reg_wdata;
			if (wr_ctrl)
				global_pullup_disable_r <= reg_wdata[`GPO_PUD_BIT];
		end
	end

	// pad drivers off and pull-ups off in reset
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pad_out_r    <= `GPO_RST_BYTE;
			pad_oe_r     <= `GPO_RST_BYTE;
			pad_pullup_r <= `GPO_RST_BYTE;   // R5
		end else begin
			pad_out_r    <= drv_val;
			pad_oe_r     <= drv_en;
			pad_pullup_r <= pu_en;
		end
	end

	// input register and raw tap
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			sync_stage_r     <= `GPO_RST_BYTE;
			sync_input_bit_r <= `GPO_RST_BYTE;
			raw_r            <= `GPO_RST_BYTE;
			rdata_r          <= `GPO_RST_BYTE;
		end else begin
			sync_stage_r     <= gated_in;
			sync_input_bit_r <= sync_stage_r;   // R17
			raw_r            <= gated_in;       // R11
			rdata_r          <= reg_rd ? rdata_nxt : 8'h00;
		end
	end

	assign reg_rdata         = rdata_r;
	assign pad_out           = pad_out_r;
	assign pad_oe            = pad_oe_r;
	assign pad_pullup        = pad_pullup_r;
	assign raw_digital_input = raw_r;

	a_pullup_reset: assert property (@(posedge core_clk) reset |=> pad_pullup == 8'h00) // R5
		else $error("pull-up active in reset");
	a_dir_override: assert property (@(posedge core_clk) disable iff (reset)
		1'b1 |=> pad_oe == $past((dir_override_en & dir_override_val)
		| (~dir_override_en & direction_bit_r))) // R7
		else $error("driver enable wrong");
	a_value_override: assert property (@(posedge core_clk) disable iff (reset)
		out_value_override_en[0] |=> pad_out[0] == $past(out_value_override_val[0])) // R8
		else $error("driven value wrong");
	a_pullup_rule: assert property (@(posedge core_clk) disable iff (reset)
		(pullup_override_en[0] == 1'b0 && global_pullup_disable_r) |=> !pad_pullup[0]) // R18
		else $error("pull-up with global disable");
	a_pullup_ovr: assert property (@(posedge core_clk) disable iff (reset)
		pullup_override_en[1] |=> pad_pullup[1] == $past(pullup_override_val[1])) // R6
		else $error("pull-up override ignored");
	a_toggle_ovr: assert property (@(posedge core_clk) disable iff (reset)
		(out_toggle_override_en[0] && !reg_wr) |=> output_bit_r[0] != $past(output_bit_r[0])) // R9
		else $error("toggle override ignored");
	a_in_toggle: assert property (@(posedge core_clk) disable iff (reset)
		(wr_in && reg_wdata[1] && !out_toggle_override_en[1])
		|=> output_bit_r[1] != $past(output_bit_r[1])) // R16
		else $error("input location write failed to toggle");
	a_sleep_clamp: assert property (@(posedge core_clk) disable iff (reset)
		(sleep_clamp && !ext_int_enabled[0] && !input_en_override_en[0])
		|=> raw_digital_input[0] == 1'b0) // R2
		else $error("input not clamped");
	a_readback: assert property (@(posedge core_clk) disable iff (reset)
		(drv_en[2] && in_en[2]) ##1 (drv_en[2] && in_en[2])
		|=> sync_input_bit_r[2] == $past(drv_val[2], 2)) // R17
		else $error("readback delay wrong");

	// pin 5 held high, clamped, then released
	sequence s_pin5_clamped;
		sleep_clamp && !ext_int_enabled[5] && !input_en_override_en[5];
	endsequence

	sequence s_pin5_released;
		!sleep_clamp && !input_en_override_en[5] && fb_in[5];
	endsequence

	sequence s_rd_ctrl;
		reg_rd && (reg_addr == `GPO_ADDR_CTRL);
	endsequence

	sequence s_wr_dir;
		reg_wr && (reg_addr == `GPO_ADDR_DIR);
	endsequence

	a_oe_reset: assert property ( // R5
		@(posedge core_clk)
		reset
		|=> pad_oe == 8'h00
	) else $error("driver enabled in reset");

	a_out_reset: assert property ( // R5
		@(posedge core_clk)
		reset
		|=> pad_out == 8'h00
	) else $error("drive value set in reset");

	a_raw_reset: assert property ( // R5
		@(posedge core_clk)
		reset
		|=> raw_digital_input == 8'h00
	) else $error("raw input set in reset");

	a_dir_default: assert property ( // R7
		@(posedge core_clk) disable iff (reset)
		!dir_override_en[0]
		|=> pad_oe[0] == $past(direction_bit_r[0])
	) else $error("driver enable ignores direction bit");

	a_value_default: assert property ( // R8
		@(posedge core_clk) disable iff (reset)
		!out_value_override_en[0]
		|=> pad_out[0] == $past(output_bit_r[0])
	) else $error("drive value ignores output bit");

	a_pullup_normal: assert property ( // R6
		@(posedge core_clk) disable iff (reset)
		!pullup_override_en[0]
		|=> pad_pullup[0] == $past(!direction_bit_r[0] && output_bit_r[0] && !global_pullup_disable_r)
	) else $error("pull-up wrong without override");

	a_pullup_output: assert property ( // R15
		@(posedge core_clk) disable iff (reset)
		!pullup_override_en[2] && direction_bit_r[2]
		|=> !pad_pullup[2]
	) else $error("pull-up on output pin");

	a_clamp_bypass: assert property ( // R3
		@(posedge core_clk) disable iff (reset)
		sleep_clamp && ext_int_enabled[3] && !input_en_override_en[3]
		|=> raw_digital_input[3] == $past(fb_in[3])
	) else $error("interrupt pin clamped");

	a_clamp_pin1: assert property ( // R2
		@(posedge core_clk) disable iff (reset)
		sleep_clamp && !ext_int_enabled[1] && !input_en_override_en[1]
		|=> !raw_digital_input[1]
	) else $error("pin 1 not clamped");

	a_ie_override: assert property ( // R10
		@(posedge core_clk) disable iff (reset)
		input_en_override_en[4]
		|=> raw_digital_input[4] == $past(fb_in[4] && input_en_override_val[4])
	) else $error("input enable override ignored");

	a_ie_disable: assert property ( // R10
		@(posedge core_clk) disable iff (reset)
		input_en_override_en[6] && !input_en_override_val[6]
		|=> !raw_digital_input[6]
	) else $error("input not disabled by override");

	a_raw_tap: assert property ( // R11
		@(posedge core_clk) disable iff (reset)
		1'b1
		|=> raw_digital_input == $past(gated_in)
	) else $error("raw tap not one stage after gate");

	a_sync_chain: assert property ( // R17
		@(posedge core_clk) disable iff (reset)
		1'b1
		|-> ##2 sync_input_bit_r == $past(gated_in, 2)
	) else $error("input register latency wrong");

	a_wake_edge: assert property ( // R4
		@(posedge core_clk) disable iff (reset)
		s_pin5_clamped ##1 s_pin5_released
		|=> $rose(raw_digital_input[5])
	) else $error("no edge on wake");

	a_ctrl_read: assert property ( // R18
		@(posedge core_clk) disable iff (reset)
		s_rd_ctrl
		|=> reg_rdata[7:1] == 7'h00
	) else $error("unused control bits read nonzero");

	a_rdata_idle: assert property ( // R13
		@(posedge core_clk) disable iff (reset)
		!reg_rd
		|=> reg_rdata == 8'h00
	) else $error("read data without strobe");

	a_dir_write: assert property ( // R15
		@(posedge core_clk) disable iff (reset)
		s_wr_dir
		|=> direction_bit_r == $past(reg_wdata)
	) else $error("direction write lost");

	a_out_write: assert property ( // R15
		@(posedge core_clk) disable iff (reset)
		wr_out && (out_toggle_override_en == 8'h00)
		|=> output_bit_r == $past(reg_wdata)
	) else $error("output write lost");

	a_out_hold: assert property ( // R16
		@(posedge core_clk) disable iff (reset)
		!reg_wr && (out_toggle_override_en == 8'h00)
		|=> $stable(output_bit_r)
	) else $error("output bit changed on its own");

	a_pud_write: assert property ( // R18
		@(posedge core_clk) disable iff (reset)
		wr_ctrl
		|=> global_pullup_disable_r == $past(reg_wdata[`GPO_PUD_BIT])
	) else $error("pull-up disable write lost");

	a_rd_dir: assert property ( // R15
		@(posedge core_clk) disable iff (reset)
		reg_rd && (reg_addr == `GPO_ADDR_DIR)
		|=> reg_rdata == $past(direction_bit_r)
	) else $error("direction read wrong");

	a_rd_out: assert property ( // R16
		@(posedge core_clk) disable iff (reset)
		reg_rd && (reg_addr == `GPO_ADDR_OUT)
		|=> reg_rdata == $past(output_bit_r)
	) else $error("output read wrong");

	a_rd_in: assert property ( // R17
		@(posedge core_clk) disable iff (reset)
		reg_rd && (reg_addr == `GPO_ADDR_IN)
		|=> reg_rdata == $past(sync_input_bit_r)
	) else $error("input read wrong");
endmodule // gpo_port

// *** tb/gpo_pad_model.sv ***
`timescale 1ns/1ns
module gpo_pad_model
import gpo_pkg::*;
(
	input  wire gpo_byte_t pad_out,
	input  wire gpo_byte_t pad_oe,
	input  wire gpo_byte_t pad_pullup,
	input  wire gpo_byte_t board_level,
	output      gpo_byte_t pad_in
);
	// own driver wins, then the pull-up, then the board
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & (pad_pullup | board_level));
endmodule // gpo_pad_model

// *** tb/testbench.sv ***
`timescale 1ns/1ns
module testbench;
import gpo_pkg::*;
logic core_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, sleep_clamp = 0;
gpo_addr_t reg_addr = 0;
gpo_byte_t reg_wdata = 0, ext_int_enabled = 0, board_level = 8'h3c, rdv;
gpo_byte_t pullup_override_en = 0, pullup_override_val = 0, dir_override_en = 0;
gpo_byte_t dir_override_val = 0, out_value_override_en = 0, out_value_override_val = 0;
gpo_byte_t out_toggle_override_en = 0, input_en_override_en = 0, input_en_override_val = 0;
gpo_byte_t pad_in, pad_out, pad_oe, pad_pullup, raw_digital_input, reg_rdata;
int error_cnt = 0, total_checks = 0;
always #20 core_clk = ~core_clk;
gpo_port DUT (.core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.sleep_clamp, .ext_int_enabled, .pad_in, .pad_out, .pad_oe, .pad_pullup,
	.pullup_override_en, .pullup_override_val, .dir_override_en, .dir_override_val,
	.out_value_override_en, .out_value_override_val, .out_toggle_override_en,
	.input_en_override_en, .input_en_override_val, .raw_digital_input);
gpo_pad_model board (.pad_out, .pad_oe, .pad_pullup, .board_level, .pad_in);
task complete_run;
	$display("errors %0d checks %0d", error_cnt, total_checks);
	if (error_cnt == 0 && total_checks > 0)
		$display("STATUS OK");
	else
		$display("STATUS NOT OK");
	$finish;
endtask
task chk(input gpo_byte_t got, input gpo_byte_t exp);
	total_checks++;
	if (got !== exp) begin
		error_cnt++;
		$display("Error at %0t: got %h expected %h", $time, got, exp);
	end
endtask
task wr(input gpo_addr_t a, input gpo_byte_t d);
	@(posedge core_clk);
	reg_addr <= a;
	reg_wdata <= d;
	reg_wr <= 1'b1;
	@(posedge core_clk);
	reg_wr <= 1'b0;
endtask
task rd(input gpo_addr_t a, input gpo_byte_t exp);
	@(posedge core_clk);
	reg_addr <= a;
	reg_rd <= 1'b1;
	@(posedge core_clk);
	reg_rd <= 1'b0;
	#1 chk(reg_rdata, exp);
endtask
task settle;
	repeat (6) @(posedge core_clk);
	#1;
endtask
task t_regs;
	wr(2'h1, 8'hff);
	wr(2'h2, 8'h5a);
	@(posedge core_clk);
	rd(2'h0, 8'h5a);
	chk(pad_oe, 8'hff);
	chk(pad_out, 8'h5a);
	wr(2'h0, 8'h0f);
	rd(2'h2, 8'h55);
	wr(2'h1, 8'h00);
	wr(2'h2, 8'hf0);
	settle;
	chk(pad_pullup, 8'hf0);
	wr(2'h3, 8'h01);
	rd(2'h3, 8'h01);
	settle;
	chk(pad_pullup, 8'h00);
	wr(2'h3, 8'h00);
	settle;
	@(posedge core_clk);
	reset <= 1'b1;
	@(posedge core_clk);
	#1 chk(pad_pullup, 8'h00);
	reset <= 1'b0;
endtask
task t_override;
	@(posedge core_clk);
	pullup_override_en <= 8'hff;
	pullup_override_val <= 8'h0f;
	dir_override_en <= 8'hff;
	dir_override_val <= 8'h33;
	out_value_override_en <= 8'hff;
	out_value_override_val <= 8'h81;
	settle;
	chk(pad_pullup, 8'h0f);
	chk(pad_oe, 8'h33);
	chk(pad_out & 8'h33, 8'h01);
	@(posedge core_clk);
	pullup_override_en <= 8'h00;
	dir_override_en <= 8'h00;
	out_value_override_en <= 8'h00;
	out_toggle_override_en <= 8'h01;
	@(posedge core_clk);
	out_toggle_override_en <= 8'h00;
	rd(2'h2, 8'h01);
endtask
task t_sleep;
	wr(2'h2, 8'h00);
	ext_int_enabled <= 8'h0c;
	settle;
	chk(raw_digital_input, 8'h3c);
	sleep_clamp <= 1'b1;
	settle;
	chk(raw_digital_input, 8'h0c);
	input_en_override_en <= 8'hff;
	input_en_override_val <= 8'hf0;
	settle;
	chk(raw_digital_input, 8'h30);
	input_en_override_en <= 8'h00;
	settle;
	sleep_clamp <= 1'b0;
	settle;
	chk(raw_digital_input, 8'h3c);
endtask
initial begin
	#200000;
	error_cnt++;
	complete_run;
end
initial begin
	repeat (12) @(posedge core_clk);
	reset <= 1'b0;
	t_regs;
	t_override;
	t_sleep;
	complete_run;
end
endmodule // testbench
